// File: rtl/dcs_pkg.sv
// Constants and types shared by the debug command and status unit
//
// Contract
// - Sixteen-bit counter advances once per system clock.
// - Counts after debug exit; stops in debug or FFFF.
// - Host drives unit only through command codes.
// - Debug mode accepts all unless read-lock programmed.
// - Normal mode executes only 00, 02, 04, 05.
// - Code 02 returns status in every mode.
// - Code 04 writes, 05 reads control, any mode.
// - Read-lock: control write cannot clear debug bit.
// - Read-lock: register writes only hit flash controls.
// - Read-lock: flash control accepts only mass erase.
// - Read-lock disables 06, 07, 09, 0A, 0B, 0C.
// - Read-lock: program memory never read out.
// - Status bit 7 shows debug mode.
// - Status bit 6 shows processor halt.
// - Status bit 5 zero while read-lock restricts.
// - Status bit 5 one when read-lock ineffective.
// - Status bits 4..0 always read zero.
// - User mass erase refused, debug-port erase allowed.
package dcs_pkg;
  // Command codes carried on the debug link
  localparam logic [7:0] CMD_REV_RD = 8'h00;
  localparam logic [7:0] CMD_STAT_RD = 8'h02;
  localparam logic [7:0] CMD_CNT_RD = 8'h03;
  localparam logic [7:0] CMD_CTL_WR = 8'h04;
  localparam logic [7:0] CMD_CTL_RD = 8'h05;
  localparam logic [7:0] CMD_PC_WR = 8'h06;
  localparam logic [7:0] CMD_PC_RD = 8'h07;
  localparam logic [7:0] CMD_REG_WR = 8'h08;
  localparam logic [7:0] CMD_REG_RD = 8'h09;
  localparam logic [7:0] CMD_PMEM_WR = 8'h0A;
  localparam logic [7:0] CMD_PMEM_RD = 8'h0B;
  localparam logic [7:0] CMD_DMEM_WR = 8'h0C;
  localparam logic [7:0] CMD_DMEM_RD = 8'h0D;
  // Status register layout
  localparam int STAT_DBG_BIT = 7;
  localparam int STAT_HALT_BIT = 6;
  localparam int STAT_LOCK_BIT = 5;
  localparam logic [4:0] STAT_RSVD_VAL = 5'h00;
  localparam logic [7:0] STAT_RESET = 8'h00;
  // Control register layout
  localparam int CTL_DBG_BIT = 7;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] CTL_DBG_MASK = 8'h80;
  // Runtime counter limits
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_STEP = 16'h0001;
  // Register file address width on the core side
  localparam int RADDR_W = 12;
  localparam logic [15:0] RSP_IDLE = 16'h0000;
endpackage : dcs_pkg

// File: rtl/dcs_runtime_counter.sv
// Saturating runtime counter that measures cycles between debug stops
`timescale 1ns/10ps
`default_nettype none
module dcs_runtime_counter
  import dcs_pkg::*;
#(
  parameter int WIDTH = 16
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Mode from the control register
  input wire logic debug_mode,
  // Counter value
  output logic [WIDTH-1:0] count
);
  logic was_debug; // Debug mode one cycle ago, to see the exit
  logic [WIDTH-1:0] next_count;
  logic next_was_debug;

  // Next value: restart on exit, hold in debug, stop at the top
  always_comb
  begin
    next_was_debug = debug_mode;
    next_count = count;
    if (debug_mode)
    begin
      next_count = count;
    end
    else if (was_debug)
    begin
      // First cycle outside debug counts as cycle one
      next_count = WIDTH'(CNT_STEP);
    end
    else if (count != WIDTH'(CNT_MAX))
    begin
      next_count = count + WIDTH'(CNT_STEP);
    end
    // At the top it simply holds; wrapping would fake a short interval
  end

  // Registers only
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      count <= WIDTH'(CNT_RESET);
      was_debug <= 1'b0;
    end
    else
    begin
      count <= next_count;
      was_debug <= next_was_debug;
    end
  end
endmodule // dcs_runtime_counter
`default_nettype wire

// File: rtl/dcs_debug_unit.sv
// Debug command decoder, mode and read-lock gating, status and counter
`timescale 1ns/10ps
`default_nettype none
module dcs_debug_unit
  import dcs_pkg::*;
#(
  parameter logic [7:0] REVISION = 8'h5A, // Arbitrary revision value
  parameter logic [RADDR_W-1:0] FLASH_REG_LO = 12'hFF8, // Flash control block start
  parameter logic [RADDR_W-1:0] FLASH_REG_HI = 12'hFF9, // Flash control block end
  parameter logic [RADDR_W-1:0] FLASH_CTL_ADDR = 12'hFF8, // Flash control register
  parameter logic [7:0] MASS_ERASE_VAL = 8'h63 // Mass erase command value
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Command from the debug link
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [RADDR_W-1:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  // Answer to the debug link
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  // System state
  input wire logic halt_mode,
  input wire logic flash_read_lock_option,
  input wire logic user_mass_erase_req,
  // Requests forwarded to the core
  output logic core_cmd_valid,
  output logic [7:0] core_cmd_code,
  output logic [RADDR_W-1:0] core_addr,
  output logic [7:0] core_data,
  input wire logic core_rd_valid,
  input wire logic [7:0] core_rd_data,
  // Flash mass erase and refusal
  output logic mass_erase_go,
  output logic user_erase_refused,
  // Mode and status
  output logic debug_mode_ctl_bit,
  output logic [7:0] debug_state_flags
);
  logic [7:0] ctl; // Debug control register
  logic [15:0] run_count; // Runtime counter value
  logic lock; // Read-lock restricts commands
  logic read_lock_effect_flag; // Status view: one when lock has no effect
  logic accept; // Command is legal now
  logic to_core; // Accepted command is carried by the core
  logic [7:0] status_now; // Live status byte
  logic [7:0] next_ctl;
  logic next_rsp_valid;
  logic [15:0] next_rsp_data;
  logic next_core_valid;
  logic [7:0] next_core_code;
  logic [RADDR_W-1:0] next_core_addr;
  logic [7:0] next_core_data;
  logic next_erase;
  logic next_refused;

  assign debug_mode_ctl_bit = ctl[CTL_DBG_BIT];
  assign lock = flash_read_lock_option;
  assign read_lock_effect_flag = ~lock;

  // Live status byte, low bits tied to the reserved value
  always_comb
  begin
    status_now = STAT_RESET;
    status_now[STAT_DBG_BIT] = debug_mode_ctl_bit;
    status_now[STAT_HALT_BIT] = halt_mode;
    status_now[STAT_LOCK_BIT] = read_lock_effect_flag;
    status_now[4:0] = STAT_RSVD_VAL;
  end

  // Gate each code by mode and read-lock; anything else is dropped
  always_comb
  begin
    accept = 1'b0;
    to_core = 1'b0;
    unique case (cmd_code)
      CMD_REV_RD, CMD_STAT_RD, CMD_CTL_WR, CMD_CTL_RD:
      begin
        accept = 1'b1;
      end
      CMD_CNT_RD:
      begin
        accept = debug_mode_ctl_bit;
      end
      CMD_PC_WR, CMD_PC_RD, CMD_REG_RD, CMD_PMEM_WR, CMD_PMEM_RD, CMD_DMEM_WR:
      begin
        // Program memory and core state stay hidden under lock
        accept = debug_mode_ctl_bit && !lock;
        to_core = accept;
      end
      CMD_REG_WR:
      begin
        if (!lock)
        begin
          accept = debug_mode_ctl_bit;
        end
        else if (cmd_addr < FLASH_REG_LO || cmd_addr > FLASH_REG_HI)
        begin
          accept = 1'b0;
        end
        else if (cmd_addr == FLASH_CTL_ADDR)
        begin
          accept = debug_mode_ctl_bit && (cmd_data == MASS_ERASE_VAL);
        end
        else
        begin
          accept = debug_mode_ctl_bit;
        end
        to_core = accept;
      end
      CMD_DMEM_RD:
      begin
        accept = debug_mode_ctl_bit;
        to_core = accept;
      end
      default:
      begin
        accept = 1'b0;
      end
    endcase
  end

  // Next control value, answer and core request
  always_comb
  begin
    next_ctl = ctl;
    next_rsp_valid = 1'b0;
    next_rsp_data = RSP_IDLE;
    next_core_valid = 1'b0;
    next_core_code = core_cmd_code;
    next_core_addr = core_addr;
    next_core_data = core_data;
    next_erase = 1'b0;
    // User code may never mass erase; only the link path drives it
    next_refused = user_mass_erase_req;
    if (cmd_valid && accept)
    begin
      unique case (cmd_code)
        CMD_REV_RD:
        begin
          next_rsp_valid = 1'b1;
          next_rsp_data = {8'h00, REVISION};
        end
        CMD_STAT_RD:
        begin
          next_rsp_valid = 1'b1;
          next_rsp_data = {8'h00, status_now};
        end
        CMD_CNT_RD:
        begin
          next_rsp_valid = 1'b1;
          next_rsp_data = run_count;
        end
        CMD_CTL_WR:
        begin
          // Under lock a set debug bit survives; other bits still land
          next_ctl = cmd_data | (lock ? (ctl & CTL_DBG_MASK) : CTL_RESET);
        end
        CMD_CTL_RD:
        begin
          next_rsp_valid = 1'b1;
          next_rsp_data = {8'h00, ctl};
        end
        default:
        begin
          next_rsp_valid = 1'b0;
        end
      endcase
      if (to_core)
      begin
        next_core_valid = 1'b1;
        next_core_code = cmd_code;
        next_core_addr = cmd_addr;
        next_core_data = cmd_data;
        next_erase = (cmd_code == CMD_REG_WR) && (cmd_addr == FLASH_CTL_ADDR)
                     && (cmd_data == MASS_ERASE_VAL);
      end
    end
    // Core read data is passed on when no local answer competes
    if (core_rd_valid && !next_rsp_valid)
    begin
      next_rsp_valid = 1'b1;
      next_rsp_data = {8'h00, core_rd_data};
    end
  end

  // Registers only
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctl <= CTL_RESET;
      rsp_valid <= 1'b0;
      rsp_data <= RSP_IDLE;
      core_cmd_valid <= 1'b0;
      core_cmd_code <= CMD_REV_RD;
      core_addr <= '0;
      core_data <= 8'h00;
      mass_erase_go <= 1'b0;
      user_erase_refused <= 1'b0;
      debug_state_flags <= STAT_RESET;
    end
    else
    begin
      ctl <= next_ctl;
      rsp_valid <= next_rsp_valid;
      rsp_data <= next_rsp_data;
      core_cmd_valid <= next_core_valid;
      core_cmd_code <= next_core_code;
      core_addr <= next_core_addr;
      core_data <= next_core_data;
      mass_erase_go <= next_erase;
      user_erase_refused <= next_refused;
      debug_state_flags <= status_now;
    end
  end

  // Runtime counter
  dcs_runtime_counter #(
    .WIDTH(16)
  ) u_counter (
    .mclk(mclk),
    .resetn(resetn),
    .debug_mode(debug_mode_ctl_bit),
    .count(run_count)
  );

  // Counter advances by one outside debug below the top
  property p_cnt_step;
    @(posedge mclk) disable iff (!resetn)
    (!debug_mode_ctl_bit && $past(!debug_mode_ctl_bit) && run_count != CNT_MAX)
      |=> (run_count == $past(run_count) + CNT_STEP) || debug_mode_ctl_bit;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("counter did not step");

  // Counter frozen while in debug and held at the top outside debug
  property p_cnt_hold;
    @(posedge mclk) disable iff (!resetn)
    ((debug_mode_ctl_bit && $past(debug_mode_ctl_bit)) ||
     (run_count == CNT_MAX && !debug_mode_ctl_bit && !$past(debug_mode_ctl_bit)))
      |=> $stable(run_count);
  endproperty
  a_cnt_hold: assert property (p_cnt_hold) else $error("counter moved when held");

  // Status byte mirrors mode, halt and lock one cycle later
  property p_status;
    @(posedge mclk) disable iff (!resetn)
    1'b1 |=> debug_state_flags == {$past(debug_mode_ctl_bit), $past(halt_mode),
                                   !$past(flash_read_lock_option), 5'h00};
  endproperty
  a_status: assert property (p_status) else $error("status byte wrong");

  // Status read answered next cycle with the status byte
  property p_stat_rd;
    @(posedge mclk) disable iff (!resetn)
    (cmd_valid && cmd_code == CMD_STAT_RD)
      |=> rsp_valid && rsp_data[7:0] == {$past(debug_mode_ctl_bit), $past(halt_mode),
                                         !$past(flash_read_lock_option), 5'h00};
  endproperty
  a_stat_rd: assert property (p_stat_rd) else $error("status read not answered");

  // Normal mode forwards nothing to the core
  property p_normal_block;
    @(posedge mclk) disable iff (!resetn)
    (cmd_valid && !debug_mode_ctl_bit) |=> !core_cmd_valid;
  endproperty
  a_normal_block: assert property (p_normal_block) else $error("core command in normal");

  // Locked debug bit cannot be cleared by a control write
  property p_dbg_keep;
    @(posedge mclk) disable iff (!resetn)
    (cmd_valid && cmd_code == CMD_CTL_WR && flash_read_lock_option && debug_mode_ctl_bit)
      |=> debug_mode_ctl_bit;
  endproperty
  a_dbg_keep: assert property (p_dbg_keep) else $error("debug bit cleared under lock");

  // Locked program memory read never reaches the core
  property p_lock_pmem;
    @(posedge mclk) disable iff (!resetn)
    (cmd_valid && flash_read_lock_option &&
     (cmd_code == CMD_PMEM_RD || cmd_code == CMD_PC_RD || cmd_code == CMD_REG_RD))
      |=> !core_cmd_valid;
  endproperty
  a_lock_pmem: assert property (p_lock_pmem) else $error("locked read forwarded");

  // Locked register write outside flash block is dropped
  property p_lock_regwr;
    @(posedge mclk) disable iff (!resetn)
    (cmd_valid && flash_read_lock_option && cmd_code == CMD_REG_WR &&
     (cmd_addr < FLASH_REG_LO || cmd_addr > FLASH_REG_HI)) |=> !core_cmd_valid;
  endproperty
  a_lock_regwr: assert property (p_lock_regwr) else $error("locked write forwarded");

  // User erase request refused, never turned into an erase
  property p_user_erase;
    @(posedge mclk) disable iff (!resetn)
    (user_mass_erase_req && !(cmd_valid && cmd_code == CMD_REG_WR))
      |=> user_erase_refused && !mass_erase_go;
  endproperty
  a_user_erase: assert property (p_user_erase) else $error("user erase not refused");

  // Reserved code changes no control state and gives no answer of its own
  property p_reserved;
    @(posedge mclk) disable iff (!resetn)
    (cmd_valid && cmd_code == 8'h01 && !core_rd_valid)
      |=> !rsp_valid && !core_cmd_valid && $stable(debug_mode_ctl_bit);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code acted");
endmodule // dcs_debug_unit
`default_nettype wire

// File: dv/dcs_host_model.sv
// Debug host model that issues one-byte commands on the debug link
`timescale 1ns/10ps
`default_nettype none
module dcs_host_model
  import dcs_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Command link toward the unit
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic [RADDR_W-1:0] cmd_addr,
  output logic [7:0] cmd_data
);
  // Idle link carries no command
  initial
  begin
    cmd_valid = 1'b0;
    cmd_code = 8'hFF;
    cmd_addr = '0;
    cmd_data = 8'h00;
  end
  // One command, held for exactly one taking edge
  task automatic send(input logic [7:0] code, input logic [RADDR_W-1:0] addr,
                      input logic [7:0] data);
    @(posedge mclk);
    #1;
    cmd_valid = 1'b1;
    cmd_code = code;
    cmd_addr = addr;
    cmd_data = data;
    @(posedge mclk);
    #1;
    cmd_valid = 1'b0;
    // Fields flip once released so a stale value is never mistaken for live
    cmd_code = ~code;
    cmd_addr = ~addr;
    cmd_data = ~data;
  endtask
endmodule // dcs_host_model
`default_nettype wire

// File: dv/dcs_debug_unit_tb.sv
// Self-checking bench for the debug command and status unit
`timescale 1ns/10ps
`default_nettype none
module dcs_debug_unit_tb
  import dcs_pkg::*;
;
  localparam logic [7:0] REV = 8'hA5; // Arbitrary revision value
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic cmd_valid;
  logic [7:0] cmd_code;
  logic [RADDR_W-1:0] cmd_addr;
  logic [7:0] cmd_data;
  logic rsp_valid;
  logic [15:0] rsp_data;
  logic halt_mode = 1'b0;
  logic lock = 1'b0;
  logic user_req = 1'b0;
  logic core_cmd_valid;
  logic [7:0] core_cmd_code;
  logic [RADDR_W-1:0] core_addr; // Forwarded address, holds last value
  logic [7:0] core_data; // Forwarded payload, holds last value
  logic core_rd_valid = 1'b0;
  logic [7:0] core_rd_data = 8'hC3;
  logic mass_erase_go;
  logic user_erase_refused;
  logic debug_mode_ctl_bit;
  logic [7:0] debug_state_flags;
  logic got_rsp, got_core, got_erase;
  logic [15:0] rsp_val;
  int n_mismatch = 0;
  int checks_done = 0;
  // 40 MHz system clock
  always #12.5 mclk = ~mclk;
  dcs_host_model i_dcs_host_model (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data));
  dcs_debug_unit #(.REVISION(REV)) i_dcs_debug_unit (.mclk(mclk), .resetn(resetn),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .halt_mode(halt_mode),
    .flash_read_lock_option(lock), .user_mass_erase_req(user_req),
    .core_cmd_valid(core_cmd_valid), .core_cmd_code(core_cmd_code), .core_addr(core_addr),
    .core_data(core_data), .core_rd_valid(core_rd_valid), .core_rd_data(core_rd_data),
    .mass_erase_go(mass_erase_go), .user_erase_refused(user_erase_refused),
    .debug_mode_ctl_bit(debug_mode_ctl_bit), .debug_state_flags(debug_state_flags));
  // Core side answers a data read in the cycle it is forwarded
  always @(posedge mclk)
  begin
    #1;
    core_rd_valid = core_cmd_valid === 1'b1 && core_cmd_code === CMD_DMEM_RD;
  end
  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Send one command and watch four cycles for its effects
  task automatic cmd(input logic [7:0] code, input logic [RADDR_W-1:0] addr,
                     input logic [7:0] data);
    got_rsp = 1'b0;
    got_core = 1'b0;
    got_erase = 1'b0;
    rsp_val = '0;
    i_dcs_host_model.send(code, addr, data);
    repeat (4)
    begin
      if (rsp_valid === 1'b1)
      begin
        got_rsp = 1'b1;
        rsp_val = rsp_data;
      end
      if (core_cmd_valid === 1'b1) got_core = 1'b1;
      if (mass_erase_go === 1'b1) got_erase = 1'b1;
      @(posedge mclk);
      #1;
    end
  endtask
  // Verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  localparam logic [RADDR_W-1:0] FLASH_REG_HI_T = 12'hFF8;
  // Normal mode: only the small command subset acts
  task automatic t_normal();
    logic [7:0] bad [10] = '{8'h01, 8'h03, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B,
                            8'h0C, 8'h0E};
    chk({8'h00, debug_state_flags}, {8'h00, STAT_RESET});
    cmd(CMD_REV_RD, '0, 8'h00);
    chk({got_rsp, rsp_val[14:0]}, {1'b1, 7'h00, REV});
    cmd(CMD_STAT_RD, '0, 8'h00);
    chk({got_rsp, rsp_val[14:0]}, 16'h8020);
    cmd(CMD_CTL_WR, '0, 8'h15);
    cmd(CMD_CTL_RD, '0, 8'h00);
    chk({got_rsp, rsp_val[14:0]}, 16'h8015);
    foreach (bad[i])
    begin
      cmd(bad[i], FLASH_REG_HI_T, 8'h63);
      chk({13'h0000, got_rsp, got_core, got_erase}, 16'h0000);
    end
    cmd(CMD_CTL_RD, '0, 8'h00);
    chk(rsp_val, 16'h0015);
  endtask
  // Debug mode: status flags and a forwarded read
  task automatic t_debug();
    cmd(CMD_CTL_WR, '0, 8'h80);
    chk({15'h0, debug_mode_ctl_bit}, 16'h0001);
    halt_mode = 1'b1;
    cmd(CMD_STAT_RD, '0, 8'h00);
    chk(rsp_val, 16'h00E0);
    halt_mode = 1'b0;
    cmd(CMD_STAT_RD, '0, 8'h00);
    chk(rsp_val, 16'h00A0);
    cmd(CMD_DMEM_RD, 12'h010, 8'h00);
    chk({got_core, got_rsp, rsp_val[13:0]}, {2'b11, 6'h00, 8'hC3});
    chk({4'h0, core_addr}, 16'h0010);
  endtask
  // Runtime counter holds in debug, counts outside it, saturates
  task automatic t_counter();
    logic [15:0] first;
    cmd(CMD_CNT_RD, '0, 8'h00);
    first = rsp_val;
    cmd(CMD_CNT_RD, '0, 8'h00);
    chk(rsp_val, first);
    cmd(CMD_CTL_WR, '0, 8'h00);
    repeat (20) @(posedge mclk);
    cmd(CMD_CTL_WR, '0, 8'h80);
    cmd(CMD_CNT_RD, '0, 8'h00);
    // Exit lasts the write's watch window, the gap and the next write's lead-in
    chk({15'h0, rsp_val >= 16'h0018 && rsp_val <= 16'h001C}, 16'h0001);
    cmd(CMD_CTL_WR, '0, 8'h00);
    repeat (66000) @(posedge mclk);
    cmd(CMD_CTL_WR, '0, 8'h80);
    cmd(CMD_CNT_RD, '0, 8'h00);
    chk({got_rsp, rsp_val[14:0]}, {1'b1, CNT_MAX[14:0]});
    chk(rsp_val, CNT_MAX);
  endtask
  // Read-lock gating in debug mode
  task automatic t_lock();
    logic [7:0] off [6] = '{8'h06, 8'h07, 8'h09, 8'h0A, 8'h0B, 8'h0C};
    lock = 1'b1;
    cmd(CMD_STAT_RD, '0, 8'h00);
    chk(rsp_val, 16'h0080);
    cmd(CMD_CTL_WR, '0, 8'h03);
    cmd(CMD_CTL_RD, '0, 8'h00);
    chk(rsp_val, 16'h0083);
    foreach (off[i])
    begin
      cmd(off[i], 12'h010, 8'h00);
      chk({14'h0000, got_rsp, got_core}, 16'h0000);
    end
    cmd(CMD_REG_WR, 12'h010, 8'h63);
    chk({14'h0000, got_core, got_erase}, 16'h0000);
    cmd(CMD_REG_WR, 12'hFF8, 8'h55);
    chk({14'h0000, got_core, got_erase}, 16'h0000);
    cmd(CMD_REG_WR, 12'hFF8, 8'h63);
    chk({14'h0000, got_core, got_erase}, 16'h0003);
    chk({core_cmd_code, core_data}, {CMD_REG_WR, 8'h63});
    lock = 1'b0;
  endtask
  // User code erase is echoed as refused and never erases
  task automatic t_user();
    @(posedge mclk);
    #1;
    user_req = 1'b1;
    @(posedge mclk);
    #1;
    user_req = 1'b0;
    chk({14'h0000, user_erase_refused, mass_erase_go}, 16'h0002);
  endtask
  // Main sequence
  initial
  begin
    repeat (4) @(posedge mclk);
    #1;
    resetn = 1'b1;
    t_normal();
    t_debug();
    t_counter();
    t_lock();
    t_user();
    results();
  end
  // Cut a hang short
  initial
  begin
    #2000000;
    n_mismatch++;
    results();
  end
endmodule // dcs_debug_unit_tb
`default_nettype wire
